// *** shared/dvhd_pkg.sv ***
// Purpose: Constants and types for the playback volume, headset detect
//          and compressor control register group.
// Assumes: 8-bit registers reached through a byte-wide internal port.
// Notes:   Every offset, field position, reset value and count lives here.
package dvhd_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0] OFF_LEFT_PLAYBACK_VOLUME = 7'h41;
  localparam logic [6:0] OFF_RIGHT_PLAYBACK_VOLUME = 7'h42;
  localparam logic [6:0] OFF_HEADSET_DETECT_CTRL_STATUS = 7'h43;
  localparam logic [6:0] OFF_COMPRESSOR_CTRL_ONE = 7'h44;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_LEFT_PLAYBACK_VOLUME = 8'h00;
  localparam logic [7:0] RST_RIGHT_PLAYBACK_VOLUME = 8'h00;
  localparam logic [7:0] RST_HEADSET_DETECT_CTRL = 8'h00;
  localparam logic [7:0] RST_COMPRESSOR_CTRL_ONE = 8'h0f;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int HS_EN_BIT = 7;
  localparam int HS_STAT_LSB = 5;
  localparam int HS_INS_DB_LSB = 2;
  localparam int HS_BTN_DB_LSB = 0;
  localparam int DRC_RSV_BIT = 7;
  localparam int DRC_EN_LEFT_BIT = 6;
  localparam int DRC_EN_RIGHT_BIT = 5;
  localparam int DRC_THR_LSB = 2;
  localparam int DRC_HYS_LSB = 0;

  // ************************************************************
  // Detect status codes
  // ************************************************************
  localparam logic [1:0] HS_STAT_NONE = 2'h0;
  localparam logic [1:0] HS_STAT_NO_MIC = 2'h1;
  localparam logic [1:0] HS_STAT_WITH_MIC = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned REF_CLK_HZ = 1000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned REF_TICKS_PER_MS = REF_CLK_HZ / MS_PER_S;
  localparam int unsigned INS_BASE_TICK_MS = 2;
  localparam int unsigned BTN_BASE_TICK_MS = 1;
  localparam logic [2:0] INS_DB_MAX_CODE = 3'h5;
  localparam int unsigned DB_SAMPLES = 8;

  // ************************************************************
  // Volume link and soft-step selections
  // ************************************************************
  typedef enum logic [1:0] {
    DVHD_LINK_INDEP = 2'h0,
    DVHD_LINK_L_FROM_R = 2'h1,
    DVHD_LINK_R_FROM_L = 2'h2,
    DVHD_LINK_SAME = 2'h3
  } dvhd_link_e;

  typedef enum logic [1:0] {
    DVHD_STEP_EVERY = 2'h0,
    DVHD_STEP_HALF = 2'h1,
    DVHD_STEP_OFF = 2'h2,
    DVHD_STEP_RSV = 2'h3
  } dvhd_step_e;

endpackage

// *** shared/dvhd_db_if.sv ***
// Purpose: Carrier between the register group and a debounce filter.
// Assumes: All signals on the register group's clock.
// Notes:   sample is a one-cycle strobe.
`timescale 1ns/1ps
interface dvhd_db_if #(
  parameter int W = 1
);
  logic sample;
  logic bypass;
  logic [W-1:0] raw;
  logic [W-1:0] stable;

  modport ctrl (output sample, output bypass, output raw, input stable);
  modport core (input sample, input bypass, input raw, output stable);
endinterface

// *** src/dvhd_debounce.sv ***
// Purpose: Glitch filter: output follows input after equal samples.
// Assumes: raw is already synchronised to clk.
// Notes:   Bypass passes raw straight through, one cycle late.
`timescale 1ns/1ps
module dvhd_debounce #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  dvhd_db_if.core db
);

  typedef struct packed {
    logic [W-1:0] cand;
    logic [W-1:0] stable;
    logic [3:0] cnt;
  } dvhd_db_s;

  dvhd_db_s st_r;
  dvhd_db_s st_nxt;

  localparam logic [3:0] LAST = 4'(dvhd_pkg::DB_SAMPLES - 1);

  always_comb begin
    st_nxt = st_r;
    if (db.bypass) begin
      st_nxt.stable = db.raw;
      st_nxt.cand = db.raw;
      st_nxt.cnt = 4'h0;
    end else if (db.sample) begin
      if (db.raw != st_r.cand) begin
        st_nxt.cand = db.raw;
        st_nxt.cnt = 4'h0;
      end else if (st_r.cnt >= LAST - 4'h1) begin
        // Eight equal samples in a row settle the level
        st_nxt.stable = st_r.cand;
        st_nxt.cnt = LAST;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign db.stable = st_r.stable;

endmodule

// *** src/dvhd_regs.sv ***
// Purpose: Playback volume, headset detect and compressor control group.
// Assumes: Byte-wide register port from the serial control decoder;
//          sample_tick and ref_tick_1mhz are strobes on clk.
// Notes:   Headset pins are asynchronous and pass two flip-flops.
`timescale 1ns/1ps
module dvhd_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] vol_link_sel,
  input wire logic [1:0] soft_step_sel,
  input wire logic sample_tick,
  input wire logic ref_tick_1mhz,
  input wire logic hs_plug_pin,
  input wire logic hs_mic_pin,
  input wire logic hs_button_pin,
  output logic [7:0] vol_left_eff,
  output logic [7:0] vol_right_eff,
  output logic dynamic_range_compressor_en_left,
  output logic dynamic_range_compressor_en_right,
  output logic [2:0] dynamic_range_compressor_threshold,
  output logic [1:0] dynamic_range_compressor_hysteresis,
  output logic [1:0] hs_status,
  output logic hs_button,
  output logic hs_button_press
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] vol_l;
    logic [7:0] vol_r;
    logic [7:0] hs_ctrl;
    logic [7:0] drc1;
    logic [1:0] hs_stat;
    logic [7:0] rdata;
    logic [7:0] eff_l;
    logic [7:0] eff_r;
    logic half;
    logic [9:0] ref_cnt;
    logic ms_tick;
    logic [6:0] ins_cnt;
    logic [2:0] btn_cnt;
    logic ins_smp;
    logic btn_smp;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic btn;
    logic btn_evt;
  } dvhd_regs_s;

  dvhd_regs_s st_r;
  dvhd_regs_s st_nxt;

  localparam logic [9:0] REF_LAST = 10'(dvhd_pkg::REF_TICKS_PER_MS - 1);
  localparam logic [6:0] INS_BASE = 7'(dvhd_pkg::INS_BASE_TICK_MS);
  localparam logic [2:0] BTN_BASE = 3'(dvhd_pkg::BTN_BASE_TICK_MS);

  // ************************************************************
  // Debounce filters
  // ************************************************************
  dvhd_db_if #(.W(2)) ins_if ();
  dvhd_db_if #(.W(1)) btn_if ();

  dvhd_debounce #(.W(2)) u_ins_db (
    .clk(clk),
    .sys_rst(sys_rst),
    .db(ins_if.core)
  );

  dvhd_debounce #(.W(1)) u_btn_db (
    .clk(clk),
    .sys_rst(sys_rst),
    .db(btn_if.core)
  );

  assign ins_if.sample = st_r.ins_smp;
  assign ins_if.bypass = 1'b0;
  assign ins_if.raw = st_r.pin_s2[1:0];
  assign btn_if.sample = st_r.btn_smp;
  assign btn_if.bypass = (st_r.hs_ctrl[1:0] == 2'h0);
  assign btn_if.raw = st_r.pin_s2[2];

  // Signed step of one half-dB toward the target
  function automatic logic [7:0] step_to(
    input logic [7:0] cur,
    input logic [7:0] tgt
  );
    logic [7:0] res;
    res = cur;
    if ($signed(cur) < $signed(tgt)) begin
      res = cur + 8'h01;
    end else if ($signed(cur) > $signed(tgt)) begin
      res = cur - 8'h01;
    end
    return res;
  endfunction

  logic [7:0] tgt_l;
  logic [7:0] tgt_r;
  logic [2:0] ins_code;
  logic [6:0] ins_last;
  logic [2:0] btn_last;
  logic do_step;
  logic [1:0] det;

  always_comb begin
    // Link chooses whose programmed value each channel follows
    tgt_l = (vol_link_sel == dvhd_pkg::DVHD_LINK_L_FROM_R) ?
            st_r.vol_r : st_r.vol_l;
    tgt_r = (vol_link_sel == dvhd_pkg::DVHD_LINK_R_FROM_L) ?
            st_r.vol_l : st_r.vol_r;
    // Reserved codes clamp to the longest time, never a shorter one
    ins_code = st_r.hs_ctrl[4:2];
    if (ins_code > dvhd_pkg::INS_DB_MAX_CODE) begin
      ins_code = dvhd_pkg::INS_DB_MAX_CODE;
    end
    ins_last = (INS_BASE << ins_code) - 7'h01;
    btn_last = 3'h0;
    if (st_r.hs_ctrl[1:0] != 2'h0) begin
      btn_last = (BTN_BASE << (st_r.hs_ctrl[1:0] - 2'h1)) - 3'h1;
    end
    det = ins_if.stable;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    do_step = 1'b0;
    st_nxt.pin_s1 = {hs_button_pin, hs_mic_pin, hs_plug_pin};
    st_nxt.pin_s2 = st_r.pin_s1;

    // Millisecond tick from the reference strobe
    st_nxt.ms_tick = 1'b0;
    if (ref_tick_1mhz) begin
      if (st_r.ref_cnt >= REF_LAST) begin
        st_nxt.ref_cnt = 10'h000;
        st_nxt.ms_tick = 1'b1;
      end else begin
        st_nxt.ref_cnt = st_r.ref_cnt + 10'h001;
      end
    end

    st_nxt.ins_smp = 1'b0;
    st_nxt.btn_smp = 1'b0;
    if (st_r.ms_tick) begin
      if (st_r.ins_cnt >= ins_last) begin
        st_nxt.ins_cnt = 7'h00;
        st_nxt.ins_smp = 1'b1;
      end else begin
        st_nxt.ins_cnt = st_r.ins_cnt + 7'h01;
      end
      if (st_r.btn_cnt >= btn_last) begin
        st_nxt.btn_cnt = 3'h0;
        st_nxt.btn_smp = 1'b1;
      end else begin
        st_nxt.btn_cnt = st_r.btn_cnt + 3'h1;
      end
    end

    // Detect status: plug alone is 01, plug and mic is 11
    if (!st_r.hs_ctrl[dvhd_pkg::HS_EN_BIT]) begin
      st_nxt.hs_stat = dvhd_pkg::HS_STAT_NONE;
    end else if (!det[0]) begin
      st_nxt.hs_stat = dvhd_pkg::HS_STAT_NONE;
    end else if (det[1]) begin
      st_nxt.hs_stat = dvhd_pkg::HS_STAT_WITH_MIC;
    end else begin
      st_nxt.hs_stat = dvhd_pkg::HS_STAT_NO_MIC;
    end

    // Button only meaningful with detection on
    st_nxt.btn = st_r.hs_ctrl[dvhd_pkg::HS_EN_BIT] & btn_if.stable[0];
    st_nxt.btn_evt = st_nxt.btn & ~st_r.btn;

    // Soft stepping of the applied volume
    if (sample_tick) begin
      st_nxt.half = ~st_r.half;
    end
    case (dvhd_step_sel(soft_step_sel))
      dvhd_pkg::DVHD_STEP_HALF: begin
        do_step = sample_tick & st_r.half;
      end
      dvhd_pkg::DVHD_STEP_OFF: begin
        do_step = 1'b0;
      end
      default: begin
        do_step = sample_tick;
      end
    endcase
    if (soft_step_sel == dvhd_pkg::DVHD_STEP_OFF) begin
      st_nxt.eff_l = tgt_l;
      st_nxt.eff_r = tgt_r;
    end else if (do_step) begin
      st_nxt.eff_l = step_to(st_r.eff_l, tgt_l);
      st_nxt.eff_r = step_to(st_r.eff_r, tgt_r);
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr == dvhd_pkg::OFF_LEFT_PLAYBACK_VOLUME) begin
        st_nxt.vol_l = reg_wdata;
      end else if (reg_addr == dvhd_pkg::OFF_RIGHT_PLAYBACK_VOLUME) begin
        st_nxt.vol_r = reg_wdata;
      end else if (reg_addr == dvhd_pkg::OFF_HEADSET_DETECT_CTRL_STATUS)
      begin
        // Status bits are not writable
        st_nxt.hs_ctrl = {reg_wdata[7], 2'h0, reg_wdata[4:0]};
      end else if (reg_addr == dvhd_pkg::OFF_COMPRESSOR_CTRL_ONE) begin
        st_nxt.drc1 = reg_wdata;
      end
    end

    // Register reads, captured in the strobe cycle, valid one cycle later
    if (reg_rd) begin
      if (reg_addr == dvhd_pkg::OFF_LEFT_PLAYBACK_VOLUME) begin
        st_nxt.rdata = st_r.vol_l;
      end else if (reg_addr == dvhd_pkg::OFF_RIGHT_PLAYBACK_VOLUME) begin
        st_nxt.rdata = st_r.vol_r;
      end else if (reg_addr == dvhd_pkg::OFF_HEADSET_DETECT_CTRL_STATUS)
      begin
        st_nxt.rdata = {st_r.hs_ctrl[7], st_r.hs_stat,
                        st_r.hs_ctrl[4:0]};
      end else if (reg_addr == dvhd_pkg::OFF_COMPRESSOR_CTRL_ONE) begin
        st_nxt.rdata = st_r.drc1;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  function automatic dvhd_pkg::dvhd_step_e dvhd_step_sel(
    input logic [1:0] sel
  );
    return dvhd_pkg::dvhd_step_e'(sel);
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.vol_l <= dvhd_pkg::RST_LEFT_PLAYBACK_VOLUME;
      st_r.vol_r <= dvhd_pkg::RST_RIGHT_PLAYBACK_VOLUME;
      st_r.hs_ctrl <= dvhd_pkg::RST_HEADSET_DETECT_CTRL;
      st_r.drc1 <= dvhd_pkg::RST_COMPRESSOR_CTRL_ONE;
      st_r.eff_l <= dvhd_pkg::RST_LEFT_PLAYBACK_VOLUME;
      st_r.eff_r <= dvhd_pkg::RST_RIGHT_PLAYBACK_VOLUME;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs, all straight from state flops
  // ************************************************************
  assign reg_rdata = st_r.rdata;
  assign vol_left_eff = st_r.eff_l;
  assign vol_right_eff = st_r.eff_r;
  assign dynamic_range_compressor_en_left =
    st_r.drc1[dvhd_pkg::DRC_EN_LEFT_BIT];
  assign dynamic_range_compressor_en_right =
    st_r.drc1[dvhd_pkg::DRC_EN_RIGHT_BIT];
  assign dynamic_range_compressor_threshold =
    st_r.drc1[dvhd_pkg::DRC_THR_LSB +: 3];
  assign dynamic_range_compressor_hysteresis =
    st_r.drc1[dvhd_pkg::DRC_HYS_LSB +: 2];
  assign hs_status = st_r.hs_stat;
  assign hs_button = st_r.btn;
  assign hs_button_press = st_r.btn_evt;

endmodule

// *** testbench/dvhd_regs_checker.sv ***
// Purpose: Port-level assertions for the volume/headset/compressor group.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Volume jump checks hold with link independent or same; they run with independent only.
`timescale 1ns/1ps
module dvhd_regs_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0] vol_link_sel,
  input wire logic [1:0] soft_step_sel,
  input wire logic [7:0] vol_left_eff,
  input wire logic [7:0] vol_right_eff,
  input wire logic dynamic_range_compressor_en_left,
  input wire logic dynamic_range_compressor_en_right,
  input wire logic [2:0] dynamic_range_compressor_threshold,
  input wire logic [1:0] dynamic_range_compressor_hysteresis,
  input wire logic [1:0] hs_status,
  input wire logic hs_button,
  input wire logic hs_button_press
);
  // ****
  // Helper state
  // ****
  logic det_en_r;
  logic det_en_nxt;
  logic [6:0] drc_t;
  logic wr44;

  assign wr44 = reg_wr && reg_addr == 7'h44;
  assign drc_t = {dynamic_range_compressor_en_left,
    dynamic_range_compressor_en_right,
    dynamic_range_compressor_threshold,
    dynamic_range_compressor_hysteresis};

  always_comb begin
    det_en_nxt = det_en_r;
    if (reg_wr && reg_addr == 7'h43) begin
      det_en_nxt = reg_wdata[7];
    end
  end

  always_ff @(posedge clk) begin
    det_en_r <= sys_rst ? 1'b0 : det_en_nxt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****
  // Assertions
  // ****
  a_status_legal: assert property (hs_status != 2'h2)
    else $error("status shows reserved code");
  // Three quiet cycles allow for the status register stage
  a_detect_off: assert property (!det_en_r && !$past(det_en_r)
    && !$past(det_en_r, 2) |-> hs_status == 2'h0 && !hs_button)
    else $error("status live while detection off");
  a_drc_left: assert property (wr44 |=>
    dynamic_range_compressor_en_left == $past(reg_wdata[6]))
    else $error("left compressor enable wrong");
  a_drc_right: assert property (wr44 |=>
    dynamic_range_compressor_en_right == $past(reg_wdata[5]))
    else $error("right compressor enable wrong");
  a_drc_fields: assert property (wr44 |=>
    drc_t[4:0] == $past(reg_wdata[4:0]))
    else $error("threshold or hysteresis wrong");
  a_drc_hold: assert property (!wr44 |=> $stable(drc_t))
    else $error("compressor controls moved without write");
  // Write lands first, the applied value follows one cycle later
  a_jump_left: assert property (reg_wr && reg_addr == 7'h41
    && soft_step_sel == 2'h2 && vol_link_sel == 2'h0 |-> ##2
    vol_left_eff == $past(reg_wdata, 2))
    else $error("left volume not applied");
  a_jump_right: assert property (reg_wr && reg_addr == 7'h42
    && soft_step_sel == 2'h2 && vol_link_sel == 2'h0 |-> ##2
    vol_right_eff == $past(reg_wdata, 2))
    else $error("right volume not applied");
  a_step_size: assert property ($stable(soft_step_sel)
    && soft_step_sel != 2'h2 |=>
    (vol_left_eff - $past(vol_left_eff)) inside {8'h00, 8'h01, 8'hff})
    else $error("soft step larger than one code");
  a_press_pulse: assert property (hs_button_press |=> !hs_button_press)
    else $error("press pulse longer than a cycle");

  c_press: cover property (hs_button_press);
  c_mic: cover property (hs_status == 2'h3);
  c_no_mic: cover property (hs_status == 2'h1);
endmodule

// *** testbench/test_dvhd_regs.sv ***
// Purpose: Self-checking bench for the register group.
// Assumes: ref tick every cycle, so 1 ms is 1000 clocks.
// Notes:   Ordinary accesses in a row table, timing cases after it.
`timescale 1ns/1ps
module test_dvhd_regs;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } dvhd_row_s;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] reg_addr = 7'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [1:0] vol_link_sel = 2'h0;
  logic [1:0] soft_step_sel = 2'h2;
  logic sample_tick = 1'b0;
  logic ref_tick_1mhz = 1'b1;
  logic hs_plug_pin = 1'b0;
  logic hs_mic_pin = 1'b0;
  logic hs_button_pin = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] vol_left_eff;
  logic [7:0] vol_right_eff;
  logic dynamic_range_compressor_en_left;
  logic dynamic_range_compressor_en_right;
  logic [2:0] dynamic_range_compressor_threshold;
  logic [1:0] dynamic_range_compressor_hysteresis;
  logic [1:0] hs_status;
  logic hs_button;
  logic hs_button_press;
  logic [7:0] drc_seen;
  assign drc_seen = {1'b0, dynamic_range_compressor_en_left,
    dynamic_range_compressor_en_right, dynamic_range_compressor_threshold,
    dynamic_range_compressor_hysteresis};
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int k;
  // Status bits of 0x43 are read-only; unmapped offsets read zero
  dvhd_row_s rows [10] = '{
    '{7'h41, 8'h30, 8'h30}, '{7'h41, 8'h81, 8'h81},
    '{7'h42, 8'h30, 8'h30}, '{7'h42, 8'hff, 8'hff},
    '{7'h43, 8'h77, 8'h17}, '{7'h44, 8'h7c, 8'h7c},
    '{7'h44, 8'h03, 8'h03}, '{7'h45, 8'h5a, 8'h00},
    '{7'h40, 8'ha5, 8'h00}, '{7'h44, 8'h6b, 8'h6b}};

  dvhd_regs u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vol_link_sel(vol_link_sel), .soft_step_sel(soft_step_sel),
    .sample_tick(sample_tick), .ref_tick_1mhz(ref_tick_1mhz),
    .hs_plug_pin(hs_plug_pin), .hs_mic_pin(hs_mic_pin),
    .hs_button_pin(hs_button_pin), .vol_left_eff(vol_left_eff),
    .vol_right_eff(vol_right_eff),
    .dynamic_range_compressor_en_left(dynamic_range_compressor_en_left),
    .dynamic_range_compressor_en_right(dynamic_range_compressor_en_right),
    .dynamic_range_compressor_threshold(dynamic_range_compressor_threshold),
    .dynamic_range_compressor_hysteresis(
      dynamic_range_compressor_hysteresis),
    .hs_status(hs_status), .hs_button(hs_button),
    .hs_button_press(hs_button_press));

  always #50 clk = ~clk;

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic lnk(input logic [1:0] s, input logic [7:0] el,
    input logic [7:0] er);
    @(posedge clk);
    vol_link_sel <= s;
    repeat (3) @(posedge clk);
    #1;
    chk(vol_left_eff, el);
    chk(vol_right_eff, er);
  endtask

  task automatic tick(input logic [7:0] e);
    @(posedge clk);
    sample_tick <= 1'b1;
    @(posedge clk);
    sample_tick <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(vol_left_eff, e);
  endtask

  task automatic ms(input int n);
    repeat (n * 1000) @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Headset waits dominate; ceiling leaves room above them
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end

  // ****
  // Sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(7'h41, 8'h00);
    rd(7'h42, 8'h00);
    rd(7'h43, 8'h00);
    rd(7'h44, 8'h0f);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
    end
    chk(drc_seen, 8'h6b);
    // Compression off before any volume link is tried
    wr(7'h44, 8'h0f);
    // Read in the write cycle still sees the old value
    @(posedge clk);
    reg_addr <= 7'h41;
    reg_wdata <= 8'h10;
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h81);
    wr(7'h42, 8'h20);
    lnk(2'h1, 8'h20, 8'h20);
    lnk(2'h2, 8'h10, 8'h10);
    lnk(2'h3, 8'h10, 8'h20);
    lnk(2'h0, 8'h10, 8'h20);
    @(posedge clk);
    soft_step_sel <= 2'h0;
    wr(7'h41, 8'h0d);
    repeat (3) @(posedge clk);
    #1;
    chk(vol_left_eff, 8'h10);
    tick(8'h0f);
    tick(8'h0e);
    tick(8'h0d);
    @(posedge clk);
    soft_step_sel <= 2'h1;
    wr(7'h41, 8'h0b);
    // Three earlier ticks leave the halving phase set: first tick steps
    tick(8'h0c);
    tick(8'h0c);
    tick(8'h0b);
    tick(8'h0b);
    // Headset: enable, insertion 16 ms, button 8 ms
    wr(7'h43, 8'h81);
    @(posedge clk);
    hs_plug_pin <= 1'b1;
    hs_mic_pin <= 1'b1;
    ms(12);
    chk({6'h0, hs_status}, 8'h00);
    ms(6);
    chk({6'h0, hs_status}, 8'h03);
    rd(7'h43, 8'he1);
    @(posedge clk);
    hs_button_pin <= 1'b1;
    ms(6);
    chk({7'h0, hs_button}, 8'h00);
    k = 0;
    while (hs_button_press !== 1'b1 && k < 4000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({7'h0, hs_button_press}, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, hs_button}, 8'h01);
    // Code 00 skips the filter, so release shows within a few cycles
    @(posedge clk);
    hs_button_pin <= 1'b0;
    wr(7'h43, 8'h80);
    repeat (8) @(posedge clk);
    #1;
    chk({7'h0, hs_button}, 8'h00);
    @(posedge clk);
    hs_mic_pin <= 1'b0;
    ms(20);
    chk({6'h0, hs_status}, 8'h01);
    wr(7'h43, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    chk({5'h0, hs_status, hs_button}, 8'h00);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(7'h44, 8'h0f);
    rd(7'h41, 8'h00);
    chk(drc_seen, 8'h0f);
    stop_test();
  end
endmodule

bind dvhd_regs dvhd_regs_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .vol_link_sel(vol_link_sel),
  .soft_step_sel(soft_step_sel), .vol_left_eff(vol_left_eff),
  .vol_right_eff(vol_right_eff),
  .dynamic_range_compressor_en_left(dynamic_range_compressor_en_left),
  .dynamic_range_compressor_en_right(dynamic_range_compressor_en_right),
  .dynamic_range_compressor_threshold(dynamic_range_compressor_threshold),
  .dynamic_range_compressor_hysteresis(dynamic_range_compressor_hysteresis),
  .hs_status(hs_status), .hs_button(hs_button),
  .hs_button_press(hs_button_press));
